//--- logic/fsml_muting.sv
// Four-sensor muting controller with APB registers and interrupt.
// Assumes sensor pins are asynchronous; pclk 100 MHz; one APB master.
module fsml_muting import fsml_pkg::*; #(
	parameter int TICK_CYCLES = TICK_CYC_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic lead_pair_sensor_one,
	input wire logic lead_pair_sensor_two,
	input wire logic trail_pair_sensor_one,
	input wire logic trail_pair_sensor_two,
	input wire logic precedence_input,
	input wire logic protective_device_output,
	output logic mute_active,
	output logic muting_error,
	output logic release_out,
	output logic irq
);
	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == OFS_CTRL) || (a == OFS_SIM_TIME) ||
			(a == OFS_TOT_TIME) || (a == OFS_STATUS) ||
			(a == OFS_IRQ_STAT) || (a == OFS_IRQ_MASK);
	endfunction

	logic [N_PINS-1:0] pin;
	logic [CTRL_W-1:0] ctrl_ff;
	logic [TIME_W-1:0] sim_time_ff, tot_time_ff;
	logic [EV_W-1:0] irq_stat_ff, irq_mask_ff, ev;
	logic [ERR_W-1:0] err_cause_ff, err_set;
	fsml_state_t state_ff, nxt_state;
	logic dir_ff, nxt_dir, prec_seen_ff, pdo_low_ff;
	logic err_ff, rel_ff, mute_ff, irq_ff, pready_ff, pslverr_ff;
	logic [31:0] prdata_ff;
	logic [$clog2(TICK_CYCLES+1)-1:0] tick_cnt_ff;
	logic tick, ovr_p, done_p, start_p, sim_exp, tot_exp;
	logic wr_en, rd_en, a_both, b_both, a_any, b_any, all4;
	logic first_both, sec_both, sec_any, sec_one, sec_two, muting;

	fsml_sync #(.W(N_PINS)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pins({protective_device_output, precedence_input,
			trail_pair_sensor_two, trail_pair_sensor_one,
			lead_pair_sensor_two, lead_pair_sensor_one}),
		.clean(pin)
	);

	assign a_both = pin[PIN_A1] & pin[PIN_A2];
	assign b_both = pin[PIN_B1] & pin[PIN_B2];
	assign a_any = pin[PIN_A1] | pin[PIN_A2];
	assign b_any = pin[PIN_B1] | pin[PIN_B2];
	assign all4 = a_both & b_both;
	assign first_both = dir_ff ? b_both : a_both;
	assign sec_both = dir_ff ? a_both : b_both;
	assign sec_any = dir_ff ? a_any : b_any;
	assign sec_one = dir_ff ? pin[PIN_A1] : pin[PIN_B1];
	assign sec_two = dir_ff ? pin[PIN_A2] : pin[PIN_B2];
	assign muting = (state_ff == ST_LEAD) || (state_ff == ST_ALL4) ||
		(state_ff == ST_TRAIL);

	// Millisecond tick; the timers count this enable, not raw cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tick_cnt_ff <= '0;
		else if (tick)
			tick_cnt_ff <= '0;
		else
			tick_cnt_ff <= tick_cnt_ff + 1'b1;
	end
	assign tick = (tick_cnt_ff ==
		($clog2(TICK_CYCLES+1))'(TICK_CYCLES - 1));

	fsml_timer #(.W(TIME_W)) u_sim_timer (
		.pclk(pclk),
		.presetn(presetn),
		.run((state_ff == ST_IDLE) &&
			((a_any && !a_both) || (b_any && !b_both))),
		.tick(tick),
		.limit(sim_time_ff),
		.expired(sim_exp)
	);

	fsml_timer #(.W(TIME_W)) u_tot_timer (
		.pclk(pclk),
		.presetn(presetn),
		.run(muting),
		.tick(tick),
		.limit(tot_time_ff),
		.expired(tot_exp)
	);

	// APB: three-cycle access, pready one cycle after penable
	assign rd_en = psel && penable && !pready_ff && !pwrite;
	assign wr_en = psel && penable && pready_ff && pwrite &&
		addr_ok(paddr);
	assign ovr_p = wr_en && (paddr == OFS_CTRL) && pwdata[CB_OVERRIDE];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff <= psel && penable && !pready_ff;
			pslverr_ff <= psel && penable && !pready_ff &&
				!addr_ok(paddr);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_ff <= '0;
		else if (rd_en) begin
			case (paddr)
			OFS_CTRL: prdata_ff <= {24'h000000, ctrl_ff};
			OFS_SIM_TIME: prdata_ff <= {16'h0000, sim_time_ff};
			OFS_TOT_TIME: prdata_ff <= {16'h0000, tot_time_ff};
			OFS_STATUS: prdata_ff <= {19'h00000, 3'(state_ff),
				4'(err_cause_ff), pdo_low_ff, prec_seen_ff, dir_ff,
				rel_ff, err_ff, mute_ff};
			OFS_IRQ_STAT: prdata_ff <= {29'h00000000, irq_stat_ff};
			OFS_IRQ_MASK: prdata_ff <= {29'h00000000, irq_mask_ff};
			default: prdata_ff <= '0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= CTRL_RST;
			sim_time_ff <= SIM_TIME_RST;
			tot_time_ff <= TOT_TIME_RST;
			irq_mask_ff <= IRQ_MASK_RST;
		end else if (wr_en) begin
			case (paddr)
			OFS_CTRL: ctrl_ff <= pwdata[CTRL_W-1:0];
			OFS_SIM_TIME: sim_time_ff <= pwdata[TIME_W-1:0];
			OFS_TOT_TIME: tot_time_ff <= pwdata[TIME_W-1:0];
			OFS_IRQ_MASK: irq_mask_ff <= pwdata[EV_W-1:0];
			default: ;
			endcase
		end
	end

	// Sequence engine
	always_comb begin
		nxt_state = state_ff;
		nxt_dir = dir_ff;
		err_set = '0;
		done_p = 1'b0;
		start_p = 1'b0;
		case (state_ff)
		ST_IDLE: begin
			if (sim_exp && ctrl_ff[CB_SIM_EN])
				err_set[ERR_SIM] = 1'b1;
			else if (all4)
				err_set[ERR_SEQ] = 1'b1;
			else if (a_both || b_both) begin
				if (ctrl_ff[CB_DIR_EN] && (b_both != ctrl_ff[CB_DIR_SEL]))
					err_set[ERR_DIR] = 1'b1;
				else if (ctrl_ff[CB_PREC_EN] && !prec_seen_ff)
					err_set[ERR_SEQ] = 1'b1;
				else begin
					nxt_state = ST_LEAD;
					nxt_dir = b_both;
					start_p = 1'b1;
				end
			end
		end
		ST_LEAD: begin
			if (all4)
				nxt_state = ST_ALL4;
			else if (!first_both)
				err_set[ERR_SEQ] = 1'b1;
			else if (ctrl_ff[CB_SEQ_MODE] && ctrl_ff[CB_SEQMON_EN] &&
				sec_two && !sec_one)
				err_set[ERR_SEQ] = 1'b1;
		end
		ST_ALL4: begin
			if (!sec_both)
				err_set[ERR_SEQ] = 1'b1;
			else if (!first_both)
				nxt_state = ST_TRAIL;
		end
		ST_TRAIL: begin
			if (ctrl_ff[CB_END_EN] && pdo_low_ff && pin[PIN_PDO])
				done_p = 1'b1;
			else if (ctrl_ff[CB_SEQ_MODE] && !sec_both)
				done_p = 1'b1;
			else if (!ctrl_ff[CB_SEQ_MODE] && !sec_any)
				done_p = 1'b1;
			if (done_p)
				nxt_state = ST_IDLE;
		end
		ST_LOCK: begin
			// Wait for a clear path so a stuck sensor cannot restart
			if (!a_any && !b_any && pin[PIN_PDO])
				nxt_state = ST_IDLE;
		end
		default: nxt_state = ST_LOCK;
		endcase
		if (muting && tot_exp && ctrl_ff[CB_TOT_EN])
			err_set[ERR_TOT] = 1'b1;
		if (err_set != '0) begin
			nxt_state = ST_LOCK;
			done_p = 1'b0;
			start_p = 1'b0;
		end
		if (ovr_p)
			nxt_state = ST_IDLE;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= ST_IDLE;
			dir_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			dir_ff <= nxt_dir;
		end
	end

	// Precedence is armed only while idle and neither sensor pair is yet full
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prec_seen_ff <= 1'b0;
		else if (state_ff != ST_IDLE)
			prec_seen_ff <= 1'b0;
		else if (pin[PIN_PREC] && !a_both && !b_both)
			prec_seen_ff <= 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pdo_low_ff <= 1'b0;
		else if (!muting)
			pdo_low_ff <= 1'b0;
		else if (!pin[PIN_PDO])
			pdo_low_ff <= 1'b1;
	end

	// New error wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_ff <= 1'b0;
			err_cause_ff <= '0;
		end else if (err_set != '0) begin
			err_ff <= 1'b1;
			err_cause_ff <= err_cause_ff | err_set;
		end else if (done_p || ovr_p) begin
			err_ff <= 1'b0;
			err_cause_ff <= '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mute_ff <= 1'b0;
			rel_ff <= 1'b0;
		end else begin
			mute_ff <= muting;
			rel_ff <= (pin[PIN_PDO] || muting) && !err_ff;
		end
	end

	assign ev = {err_set != '0, done_p, start_p};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_ff <= '0;
			irq_ff <= 1'b0;
		end else begin
			if (wr_en && paddr == OFS_IRQ_STAT)
				irq_stat_ff <= (irq_stat_ff & ~pwdata[EV_W-1:0]) | ev;
			else
				irq_stat_ff <= irq_stat_ff | ev;
			irq_ff <= |(irq_stat_ff & irq_mask_ff);
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign mute_active = mute_ff;
	assign muting_error = err_ff;
	assign release_out = rel_ff;
	assign irq = irq_ff;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_clean_start;
		state_ff == ST_IDLE && (a_both ^ b_both) && !ovr_p &&
			!ctrl_ff[CB_DIR_EN] && !ctrl_ff[CB_PREC_EN] &&
			!(sim_exp && ctrl_ff[CB_SIM_EN]);
	endsequence
	sequence s_prec_missing;
		state_ff == ST_IDLE && ctrl_ff[CB_PREC_EN] && !prec_seen_ff &&
			(a_both ^ b_both) && !ctrl_ff[CB_DIR_EN] && !ovr_p;
	endsequence

	a_start_lead: assert property (s_clean_start |=>
		state_ff == ST_LEAD ##1 mute_ff)
		else $error("muting did not start on first pair");
	a_handover_all: assert property ($rose(state_ff == ST_ALL4) |->
		$past(all4)) else $error("handover without all four sensors");
	a_trail_hold: assert property (state_ff == ST_TRAIL && sec_both &&
		err_set == '0 && !ovr_p && !done_p |=> state_ff == ST_TRAIL)
		else $error("muting dropped while second pair active");
	a_prec_order: assert property (s_prec_missing |=>
		state_ff == ST_LOCK ##1 err_ff)
		else $error("missing precedence not flagged");
	a_dir_block: assert property (state_ff == ST_IDLE && !ovr_p &&
		ctrl_ff[CB_DIR_EN] && !all4 && !(sim_exp && ctrl_ff[CB_SIM_EN])
		&& (b_both ? !ctrl_ff[CB_DIR_SEL] : (a_both &&
		ctrl_ff[CB_DIR_SEL])) |=> state_ff == ST_LOCK)
		else $error("wrong direction accepted");
	a_seq_end: assert property (state_ff == ST_TRAIL &&
		ctrl_ff[CB_SEQ_MODE] && !sec_both && !ovr_p && err_set == '0
		|=> state_ff == ST_IDLE ##1 !mute_ff)
		else $error("sequential muting did not end");
	a_sim_err: assert property (state_ff == ST_IDLE && sim_exp &&
		ctrl_ff[CB_SIM_EN] |=> err_ff && err_cause_ff[ERR_SIM])
		else $error("simultaneity error not raised");
	a_mute_valid: assert property ($rose(state_ff == ST_LEAD) |->
		$past(state_ff == ST_IDLE) && $past(a_both ^ b_both))
		else $error("muting entered outside valid sequence");
	a_par_hold: assert property (state_ff == ST_TRAIL &&
		!ctrl_ff[CB_SEQ_MODE] && sec_any && !done_p && !ovr_p &&
		err_set == '0 |=> muting)
		else $error("parallel muting ended early");
	a_err_hold: assert property (err_ff && !done_p && !ovr_p |=>
		err_ff) else $error("error cleared without cycle or override");
	a_release_err: assert property (err_ff |=> !rel_ff)
		else $error("release high during muting error");
endmodule

//--- logic/fsml_pkg.sv
// Constants shared by the four-sensor muting block.
// Assumes a 100 MHz pclk; register offsets are APB byte addresses.
package fsml_pkg;
	localparam int CLK_NS = 10;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYC_DEF = (TICK_NS + CLK_NS - 1) / CLK_NS;
	localparam int TIME_W = 16;
	localparam int SYNC_STAGES = 3;
	localparam int N_PINS = 6;
	localparam int PIN_A1 = 0;
	localparam int PIN_A2 = 1;
	localparam int PIN_B1 = 2;
	localparam int PIN_B2 = 3;
	localparam int PIN_PREC = 4;
	localparam int PIN_PDO = 5;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SIM_TIME = 8'h04;
	localparam logic [7:0] OFS_TOT_TIME = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
	localparam int CB_SEQ_MODE = 0;
	localparam int CB_DIR_EN = 1;
	localparam int CB_DIR_SEL = 2;
	localparam int CB_PREC_EN = 3;
	localparam int CB_SIM_EN = 4;
	localparam int CB_TOT_EN = 5;
	localparam int CB_END_EN = 6;
	localparam int CB_SEQMON_EN = 7;
	localparam int CB_OVERRIDE = 8;
	localparam int CTRL_W = 8;
	localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
	localparam logic [TIME_W-1:0] SIM_TIME_RST = 16'h0BB8;
	localparam logic [TIME_W-1:0] TOT_TIME_RST = 16'h2710;
	localparam int ERR_SIM = 0;
	localparam int ERR_TOT = 1;
	localparam int ERR_DIR = 2;
	localparam int ERR_SEQ = 3;
	localparam int ERR_W = 4;
	localparam int EV_START = 0;
	localparam int EV_DONE = 1;
	localparam int EV_ERR = 2;
	localparam int EV_W = 3;
	localparam logic [EV_W-1:0] IRQ_MASK_RST = 3'h0;
	typedef enum logic [2:0] {
		ST_IDLE, ST_LEAD, ST_ALL4, ST_TRAIL, ST_LOCK
	} fsml_state_t;
endpackage

//--- logic/fsml_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes asynchronous pins; output changes once stages two and three agree.
module fsml_sync import fsml_pkg::*; #(
	parameter int W = N_PINS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] pins,
	output logic [W-1:0] clean
);
	logic [W-1:0] s1_ff, s2_ff, s3_ff, clean_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
		end else begin
			s1_ff <= pins;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// Per bit: a glitch seen by one stage only never reaches the logic
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn)
				clean_ff[i] <= 1'b0;
			else if (s2_ff[i] == s3_ff[i])
				clean_ff[i] <= s3_ff[i];
		end
	end

	assign clean = clean_ff;
endmodule

//--- logic/fsml_timer.sv
// Monitoring timer counting divider ticks while run is high.
// Assumes tick is a one-cycle enable; clears as soon as run drops.
module fsml_timer import fsml_pkg::*; #(
	parameter int W = TIME_W
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic tick,
	input wire logic [W-1:0] limit,
	output logic expired
);
	logic [W-1:0] cnt_ff;
	logic exp_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt_ff <= '0;
		else if (!run)
			cnt_ff <= '0;
		else if (tick && cnt_ff != '1)
			cnt_ff <= cnt_ff + 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			exp_ff <= 1'b0;
		else
			exp_ff <= run && (cnt_ff >= limit);
	end

	assign expired = exp_ff;
endmodule

//--- test/fsml_partner.sv
// Model of the four muting sensors, precedence pin and light curtain.
// Assumes the bench picks the material position; pins follow at once.
module fsml_partner import fsml_pkg::*; (
	input wire logic [2:0] stage,
	input wire logic dir,
	input wire logic prec_on,
	input wire logic free,
	output logic lead_pair_sensor_one,
	output logic lead_pair_sensor_two,
	output logic trail_pair_sensor_one,
	output logic trail_pair_sensor_two,
	output logic precedence_input,
	output logic protective_device_output
);
	logic f1, f2, s1, s2;
	// Stage: 0 none, 1 precedence only, 2 first pair, 3 all four,
	// 4 second pair, 5 second pair sensor one free, 6 first pair partial,
	// 7 first pair with second sensor two only (wrong order)
	always_comb begin
		f1 = stage inside {3'h2, 3'h3, 3'h6, 3'h7};
		f2 = stage inside {3'h2, 3'h3, 3'h7};
		s1 = stage inside {3'h3, 3'h4};
		s2 = stage inside {3'h3, 3'h4, 3'h5, 3'h7};
		lead_pair_sensor_one = dir ? s1 : f1;
		lead_pair_sensor_two = dir ? s2 : f2;
		trail_pair_sensor_one = dir ? f1 : s1;
		trail_pair_sensor_two = dir ? f2 : s2;
		// Raised one stage ahead of the first pair when enabled
		precedence_input = prec_on && (stage inside {3'h1, 3'h2, 3'h3});
		// Curtain is blocked while material is in the field
		// Free clears the curtain early, as if the material left its field
		protective_device_output = free || stage inside {3'h0, 3'h1, 3'h6};
	end
endmodule

//--- test/tb.sv
// Self-checking bench for the muting block with the sensor model.
// Assumes a short tick divider so the monitor times stay brief.
module tb import fsml_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TK = 4;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, erv;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic [2:0] stage;
	logic dir, prec_on, free, la, lb, ta, tb_s, prc, pdo;
	logic mute_active, muting_error, release_out, irq;
	int error_cnt, n_checks, t;
	logic [7:0] ad [5] = '{OFS_CTRL, OFS_SIM_TIME, OFS_TOT_TIME,
		OFS_IRQ_MASK, 8'h18};
	logic [31:0] rv [5] = '{32'h0, 32'(SIM_TIME_RST), 32'(TOT_TIME_RST),
		32'(IRQ_MASK_RST), 32'h0};

	fsml_muting #(.TICK_CYCLES(TK)) i_fsml_muting (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .lead_pair_sensor_one(la),
		.lead_pair_sensor_two(lb), .trail_pair_sensor_one(ta),
		.trail_pair_sensor_two(tb_s), .precedence_input(prc),
		.protective_device_output(pdo), .mute_active(mute_active),
		.muting_error(muting_error), .release_out(release_out), .irq(irq));
	fsml_partner i_fsml_partner (.stage(stage), .dir(dir),
		.prec_on(prec_on), .free(free), .lead_pair_sensor_one(la),
		.lead_pair_sensor_two(lb), .trail_pair_sensor_one(ta),
		.trail_pair_sensor_two(tb_s), .precedence_input(prc),
		.protective_device_output(pdo));

	always #5 pclk = ~pclk;

	function automatic logic exp_mute(input logic [2:0] s, input logic sq);
		return (s inside {3'h2, 3'h3, 3'h4}) || (s == 3'h5 && !sq);
	endfunction
	function automatic logic exp_rel(input logic p, input logic m,
		input logic e);
		return !e && (p || m);
	endfunction

	task automatic complete_run();
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rdv = prdata;
		erv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 20) begin
			error_cnt++;
			complete_run();
		end
	endtask

	// Synchroniser and filter need four edges; random extra hold on top
	task automatic go(input logic [2:0] s);
		@(posedge pclk);
		stage <= s;
		repeat (8 + $urandom_range(0, 7)) @(posedge pclk);
	endtask

	task automatic cyc(input logic sq);
		logic [2:0] st [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0};
		logic em;
		foreach (st[k]) begin
			go(st[k]);
			em = exp_mute(st[k], sq);
			chk("mute", 32'(mute_active), 32'(em));
			chk("release", 32'(release_out), 32'(exp_rel(pdo, em, 1'b0)));
			chk("error", 32'(muting_error), 32'h0);
		end
	endtask

	task automatic bad(input logic [2:0] s);
		go(s);
		chk("mute", 32'(mute_active), 32'h0);
		chk("error", 32'(muting_error), 32'h1);
		chk("release", 32'(release_out), 32'h0);
		go(3'h0);
	endtask

	initial begin
		repeat (50000) @(posedge pclk);
		error_cnt++;
		complete_run();
	end

	initial begin
		{pclk, presetn, psel, penable, pwrite, dir, prec_on, free} = '0;
		{paddr, pwdata, stage, error_cnt, n_checks} = '0;
		void'($urandom(32'h0907382d));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (int k = 0; k < 5; k++) begin
			apb(1'b0, ad[k], 32'h0);
			chk("reg", rdv, rv[k]);
			chk("slverr", 32'(erv), 32'(k == 4));
		end
		apb(1'b1, 8'h18, 32'hFFFFFFFF);
		chk("slverr", 32'(erv), 32'h1);
		// Both directions accepted with no restriction
		dir <= 1'b0;
		cyc(1'b0);
		dir <= 1'b1;
		cyc(1'b0);
		apb(1'b1, OFS_CTRL, 32'h1);
		dir <= 1'($urandom_range(0, 1));
		cyc(1'b1);
		// Direction restricted to lead pair first
		apb(1'b1, OFS_IRQ_MASK, 32'h4);
		apb(1'b1, OFS_CTRL, 32'h6 & 32'h2);
		dir <= 1'b1;
		bad(3'h2);
		chk("irq", 32'(irq), 32'h1);
		apb(1'b1, OFS_CTRL, 32'h102);
		// The override lands at the pready edge; its effect shows one later
		@(posedge pclk);
		chk("error", 32'(muting_error), 32'h0);
		apb(1'b0, OFS_IRQ_STAT, 32'h0);
		chk("irqstat", 32'(rdv[EV_ERR]), 32'h1);
		apb(1'b1, OFS_IRQ_STAT, 32'h7);
		// Status clears at the write edge, the registered irq one edge on
		repeat (2) @(posedge pclk);
		chk("irq", 32'(irq), 32'h0);
		dir <= 1'b0;
		cyc(1'b0);
		// All four at once, then a full valid cycle clears the error
		bad(3'h3);
		go(3'h2);
		go(3'h3);
		go(3'h4);
		go(3'h0);
		chk("error", 32'(muting_error), 32'h0);
		// Precedence ahead of the first pair, then missing
		apb(1'b1, OFS_CTRL, 32'h8);
		prec_on <= 1'b1;
		cyc(1'b0);
		prec_on <= 1'b0;
		bad(3'h2);
		apb(1'b1, OFS_CTRL, 32'h100);
		// Lead pair held past a short total muting time
		apb(1'b1, OFS_TOT_TIME, 32'h3);
		apb(1'b1, OFS_CTRL, 32'h20);
		go(3'h2);
		repeat (3 * TK + 20) @(posedge pclk);
		chk("error", 32'(muting_error), 32'h1);
		chk("mute", 32'(mute_active), 32'h0);
		// Lock state, total-time cause, error flag
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("status", rdv, 32'h00001082);
		go(3'h0);
		// Curtain clears while second pair partly active: muting ends
		apb(1'b1, OFS_CTRL, 32'h140);
		go(3'h2);
		go(3'h3);
		go(3'h4);
		go(3'h5);
		chk("mute", 32'(mute_active), 32'h1);
		free <= 1'b1;
		repeat (10) @(posedge pclk);
		chk("mute", 32'(mute_active), 32'h0);
		chk("error", 32'(muting_error), 32'h0);
		free <= 1'b0;
		go(3'h0);
		// Sequential order monitor: second sensor two before sensor one
		apb(1'b1, OFS_CTRL, 32'h81);
		go(3'h2);
		go(3'h7);
		chk("error", 32'(muting_error), 32'h1);
		go(3'h0);
		apb(1'b1, OFS_CTRL, 32'h100);
		// Partial first pair held past a random simultaneity limit
		t = $urandom_range(2, 5);
		apb(1'b1, OFS_SIM_TIME, 32'(t));
		apb(1'b1, OFS_CTRL, 32'h10);
		go(3'h6);
		repeat (t * TK + 20) @(posedge pclk);
		chk("error", 32'(muting_error), 32'h1);
		complete_run();
	end
endmodule
